// [sim/ssr_slave_model.sv]
// Behavioural synchronous slave that shifts words out to the master receiver.
// Assumes the master drives the shift clock idle low and samples on its falling edge.
`timescale 1ns/10ps
module ssr_slave_model (
  input wire logic rst_b,
  input wire logic restart,
  input wire logic nine_bit,
  input wire logic [8:0] first_word,
  input wire logic shift_clock,
  input wire logic shift_clock_oe_b,
  output logic data_out
);
  logic [8:0] word_q; // Word being shifted out, LSB first.
  int bit_idx; // Next bit to present.
  // Each word sent is three above the previous one, so the bench can predict it.
  // A new bit is set up on the rising edge so it is settled at the falling one;
  // after the falling edge the line shows a wrong level on purpose, so that a
  // late sample in the master is caught.
  always @(shift_clock or posedge restart or negedge rst_b) begin
    if (!rst_b || restart) begin
      word_q = first_word;
      bit_idx = 0;
      data_out = 1'b0;
    end else if (!shift_clock_oe_b && shift_clock === 1'b1) begin
      data_out = word_q[bit_idx];
      bit_idx++;
      if (bit_idx == (nine_bit ? 9 : 8)) begin
        bit_idx = 0;
        word_q = word_q + 9'h003;
      end
    end else if (!shift_clock_oe_b) begin
      data_out = ~data_out;
    end
  end
endmodule

// [sim/ssr_sync_rx_tb.sv]
// Self-checking bench for the synchronous master receiver over APB.
// Assumes ssr_pkg and the slave model are compiled before this file.
`timescale 1ns/10ps
module ssr_sync_rx_tb;
  localparam int HALF = 8; // Shift clock half period with a divisor of 7.
  logic ref_clk, rst_b, psel, penable, pwrite, pin, restart, nine_bit;
  logic pready, pslverr, rerr, pin_o, pin_oe_b, sck, sck_oe_b, irq, sck_prev, moved;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [8:0] first_word, w;
  int fail_count = 0;
  int samples_checked = 0;
  int gap = 100; // Cycles since the last shift clock toggle.
  ssr_sync_rx ssr_sync_rx_inst (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_data_pin_i(pin), .serial_data_pin_o(pin_o),
    .serial_data_pin_oe_b(pin_oe_b), .shift_clock_o(sck), .shift_clock_oe_b(sck_oe_b),
    .irq(irq));
  ssr_slave_model ssr_slave_model_inst (.rst_b(rst_b), .restart(restart),
    .nine_bit(nine_bit), .first_word(first_word), .shift_clock(sck),
    .shift_clock_oe_b(sck_oe_b), .data_out(pin));
  // Free-running system clock at 250 MHz.
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task print_verdict;
    $display("Checks made: %0d, mismatches: %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task check_reg(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: register read %h, expected %h", $time, got, exp);
    end
  endtask
  task check_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: signal is %b, expected %b", $time, got, exp);
    end
  endtask
  task give_up;
    fail_count++;
    $display("ERROR at %0t: wait ran out", $time);
    print_verdict;
  endtask
  // One APB transfer: setup, then access until pready is seen high at an edge.
  task apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                output logic [31:0] rd, output logic err);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) give_up;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb_xfer(1'b1, a, d, rdata, rerr);
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb_xfer(1'b0, a, 32'h0, rdata, rerr);
    check_reg(rdata, exp);
  endtask
  // Two edges first, so an interrupt that is still falling is not mistaken for a new one.
  task wait_irq(input int n);
    repeat (2) @(posedge ref_clk);
    while (irq !== 1'b1 && n > 0) begin
      @(posedge ref_clk);
      n--;
    end
    if (irq !== 1'b1) give_up;
  endtask
  task chk_irq(input logic exp);
    repeat (2) @(posedge ref_clk);
    check_bit(irq, exp);
  endtask
  // The shift clock must not move at all for n cycles.
  task quiet(input int n);
    logic s0;
    s0 = sck;
    moved = 1'b0;
    repeat (n) begin
      @(posedge ref_clk);
      if (sck !== s0) moved = 1'b1;
    end
    check_bit(moved, 1'b0);
  endtask
  task load_word(input logic nine, input logic [8:0] wd);
    @(posedge ref_clk);
    nine_bit <= nine;
    first_word <= wd;
    restart <= 1'b1;
    @(posedge ref_clk);
    restart <= 1'b0;
  endtask
  // Every short interval between toggles must be one programmed half period.
  always @(posedge ref_clk) begin
    if (sck !== sck_prev && gap < 20) check_bit(gap == HALF, 1'b1);
    gap = (sck !== sck_prev) ? 1 : ((gap < 100) ? gap + 1 : gap);
    sck_prev = sck;
  end
  initial begin
    rst_b = 1'b0;
    {psel, penable, pwrite, restart, nine_bit} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    first_word = 9'h000;
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd_chk(ssr_pkg::OFF_RECEIVE_STATUS_CONTROL, 32'h0);
    check_bit(rerr, 1'b0);
    rd_chk(ssr_pkg::OFF_TRANSMIT_STATUS_CONTROL, 32'h2);
    rd_chk(ssr_pkg::OFF_INT_MASK, 32'h0);
    rd_chk(8'h20, 32'h0);
    check_bit(rerr, 1'b1);
    check_bit(sck_oe_b, 1'b1);
    check_bit(pin_oe_b, 1'b1);
    check_bit(pin_o, 1'b0);
    // Configuration order as software must follow it.
    // The high byte is ignored until the wide divisor is selected.
    wr(ssr_pkg::OFF_RATE_DIVISOR_HIGH, 32'h1);
    wr(ssr_pkg::OFF_RATE_DIVISOR_LOW, HALF - 1);
    wr(ssr_pkg::OFF_RATE_CONTROL_REGISTER, 32'h0);
    rd_chk(ssr_pkg::OFF_RATE_DIVISOR_LOW, HALF - 1);
    wr(ssr_pkg::OFF_TRANSMIT_STATUS_CONTROL, 32'h90);
    wr(ssr_pkg::OFF_RECEIVE_STATUS_CONTROL, 32'h80);
    // Receive interrupt enable; delivery past irq is up to the interrupt controller.
    wr(ssr_pkg::OFF_INT_MASK, 32'h1);
    chk_irq(1'b0);
    check_bit(sck_oe_b, 1'b0);
    // Single word, eight bits.
    load_word(1'b0, 9'h0a5);
    wr(ssr_pkg::OFF_RECEIVE_STATUS_CONTROL, 32'ha0);
    wait_irq(400);
    rd_chk(ssr_pkg::OFF_RECEIVE_STATUS_CONTROL, 32'h80);
    quiet(60);
    rd_chk(ssr_pkg::OFF_RECEIVE_DATA_REGISTER, 32'ha5);
    wr(ssr_pkg::OFF_INT_MASK, 32'h0);
    chk_irq(1'b0);
    wr(ssr_pkg::OFF_INT_MASK, 32'h1);
    chk_irq(1'b1);
    wr(ssr_pkg::OFF_INT_STATUS, 32'h1);
    chk_irq(1'b0);
    // Nine-bit words with both enables set run back to back.
    w = 9'h1c3;
    load_word(1'b1, w);
    wr(ssr_pkg::OFF_RECEIVE_STATUS_CONTROL, 32'hf0);
    for (int k = 0; k < 3; k++) begin
      wait_irq(400);
      apb_xfer(1'b0, ssr_pkg::OFF_RECEIVE_STATUS_CONTROL, 32'h0, rdata, rerr);
      check_bit(rdata[ssr_pkg::P_NINTH_BIT], w[8]);
      rd_chk(ssr_pkg::OFF_RECEIVE_DATA_REGISTER, {24'h0, w[7:0]});
      wr(ssr_pkg::OFF_INT_STATUS, 32'h1);
      w = w + 9'h003;
    end
    // Leave the next word unread so the one after it overruns.
    wr(ssr_pkg::OFF_INT_MASK, 32'h2);
    wait_irq(700);
    apb_xfer(1'b0, ssr_pkg::OFF_RECEIVE_STATUS_CONTROL, 32'h0, rdata, rerr);
    check_bit(rdata[ssr_pkg::P_OVERRUN], 1'b1);
    check_bit(rdata[ssr_pkg::P_FRAME_ERR], 1'b0);
    quiet(60);
    rd_chk(ssr_pkg::OFF_RECEIVE_DATA_REGISTER, {24'h0, w[7:0]});
    wr(ssr_pkg::OFF_RECEIVE_STATUS_CONTROL, 32'h80);
    apb_xfer(1'b0, ssr_pkg::OFF_RECEIVE_STATUS_CONTROL, 32'h0, rdata, rerr);
    check_bit(rdata[ssr_pkg::P_OVERRUN], 1'b0);
    // Inverted clock idles high; the wide divisor of 16'h0107 gives 264-cycle halves.
    wr(ssr_pkg::OFF_RATE_CONTROL_REGISTER, 32'h18);
    rd_chk(ssr_pkg::OFF_RATE_CONTROL_REGISTER, 32'h58);
    check_bit(sck, 1'b1);
    wr(ssr_pkg::OFF_RECEIVE_STATUS_CONTROL, 32'h90);
    quiet(200);
    repeat (100) @(posedge ref_clk);
    check_bit(sck, 1'b0);
    wr(ssr_pkg::OFF_RECEIVE_STATUS_CONTROL, 32'h80);
    wr(ssr_pkg::OFF_INT_STATUS, 32'h3);
    chk_irq(1'b0);
    print_verdict;
  end
endmodule

// [verilog/ssr_pkg.sv]
// Constants for the synchronous master serial receiver: register map,
// field positions, writable masks and reset values.
// Assumes a 32-bit APB port with an 8-bit byte address.
package ssr_pkg;
  // Register byte offsets, one aligned word each.
  localparam logic [7:0] OFF_RECEIVE_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] OFF_RECEIVE_DATA_REGISTER = 8'h04;
  localparam logic [7:0] OFF_TRANSMIT_STATUS_CONTROL = 8'h08;
  localparam logic [7:0] OFF_RATE_CONTROL_REGISTER = 8'h0c;
  localparam logic [7:0] OFF_RATE_DIVISOR_HIGH = 8'h10;
  localparam logic [7:0] OFF_RATE_DIVISOR_LOW = 8'h14;
  localparam logic [7:0] OFF_INT_STATUS = 8'h18;
  localparam logic [7:0] OFF_INT_MASK = 8'h1c;
  // Fields of receive_status_control.
  localparam int P_PORT_EN = 7;
  localparam int P_NINE_EN = 6;
  localparam int P_SINGLE_EN = 5;
  localparam int P_CONT_EN = 4;
  localparam int P_FRAME_ERR = 2;
  localparam int P_OVERRUN = 1;
  localparam int P_NINTH_BIT = 0;
  // Fields of transmit_status_control.
  localparam int P_CLK_MASTER = 7;
  localparam int P_SYNC_MODE = 4;
  localparam int P_SHIFT_IDLE = 1;
  // Fields of rate_control_register.
  localparam int P_RX_IDLE = 6;
  localparam int P_CLK_POL = 4;
  localparam int P_WIDE_DIV = 3;
  // Bits that software may write in each control register.
  localparam logic [7:0] RSC_WR_MASK = 8'hf8;
  localparam logic [7:0] TXS_WR_MASK = 8'hfd;
  localparam logic [7:0] RCR_WR_MASK = 8'h3b;
  // Reset value shared by all control registers.
  localparam logic [7:0] REG_RESET = 8'h00;
  // Interrupt status and mask layout.
  localparam int INT_W = 2;
  localparam int I_RX_DONE = 0;
  localparam int I_OVERRUN = 1;
  // Word length limits, counted from zero.
  localparam logic [3:0] LAST_BIT_8 = 4'h7;
  localparam logic [3:0] LAST_BIT_9 = 4'h8;
  // Receive engine states.
  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_SHIFT = 1'b1
  } ssr_state_e;
endpackage

// [verilog/ssr_sync_rx.sv]
// Receive path of a synchronous serial port acting as clock master.
// Assumes an APB master on ref_clk and a slave that changes data while
// the shift clock is high, so data is stable at the falling edge.
`timescale 1ns/10ps

// Operation
// - Either receive enable starts reception in sync mode
// - Sample data on falling shift clock edge, rising edge when clock polarity is inverted
// - Single enable receives exactly one word
// - Continuous enable receives until software clears it or an overrun halts it
// - Both enables set behaves as continuous
// - Nine-bit mode keeps ninth bit in status
// - Word done sets flag, interrupt if enabled
// - Status shows overrun errors; the framing error bit always reads zero
// - Low eight bits go to data register
// - Clearing continuous enable clears latched errors
module ssr_sync_rx (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_data_pin_i,
  output logic serial_data_pin_o,
  output logic serial_data_pin_oe_b,
  output logic shift_clock_o,
  output logic shift_clock_oe_b,
  output logic irq
);

  // True for every offset that holds a register.
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a[1:0] == 2'b00) && (a <= ssr_pkg::OFF_INT_MASK);
  endfunction
  // Input synchroniser stages and the filtered data level.
  logic s1_q, s2_q, s3_q, filt_q, filt_d;
  // Software-visible control registers.
  logic [7:0] rsc_q, rsc_d, txs_q, txs_d, rcr_q, rcr_d;
  logic [7:0] divh_q, divh_d, divl_q, divl_d;
  // Receive buffer, its full flag, the error flag and the ninth bit.
  logic [7:0] rxbuf_q, rxbuf_d;
  logic full_q, full_d, overrun_error_flag_q, overrun_error_flag_d, ninth_q, ninth_d;
  // Interrupt status and mask.
  logic [ssr_pkg::INT_W-1:0] ist_q, ist_d, imask_q, imask_d;
  // Receive engine.
  ssr_pkg::ssr_state_e st_q, st_d;
  logic [15:0] cnt_q, cnt_d;
  logic phase_q, phase_d;
  logic [3:0] bit_q, bit_d;
  logic [8:0] sh_q, sh_d;
  // Registered read data.
  logic [31:0] prdata_q, prdata_d;
  // Decoded bus strobes and engine helpers.
  logic wr, rd, setup, mode_ok, want, fall, done;
  logic [15:0] half;
  logic [8:0] sh_new;
  logic [7:0] word;
  logic [3:0] last;
  logic [7:0] rmux;
  // The data pin is only an input here, so its driver stays off.
  assign serial_data_pin_o = 1'b0;
  assign serial_data_pin_oe_b = 1'b1;
  // Zero-wait slave: read data is prepared in the setup cycle.
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~is_mapped(paddr);
  assign prdata = prdata_q;
  assign irq = |(ist_q & imask_q);
  // A data change counts only when the second and third stages agree,
  // which rejects a one-cycle glitch at the cost of a cycle of delay.
  always_comb begin
    filt_d = filt_q;
    if (s2_q == s3_q) begin
      filt_d = s3_q;
    end
  end
  // Synchroniser and filter flops.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      filt_q <= 1'b0;
    end else begin
      s1_q <= serial_data_pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= filt_d;
    end
  end
  // Bus strobes; a write or read side effect lands on the access edge.
  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;
  // Master receive needs sync mode, port enable and master clock.
  assign mode_ok = rsc_q[ssr_pkg::P_PORT_EN] & txs_q[ssr_pkg::P_SYNC_MODE]
                   & txs_q[ssr_pkg::P_CLK_MASTER];
  // Either enable starts reception; an overrun holds it off.
  assign want = mode_ok & ~overrun_error_flag_q
                & (rsc_q[ssr_pkg::P_SINGLE_EN] | rsc_q[ssr_pkg::P_CONT_EN]);
  // Half period of the shift clock in ref_clk cycles, minus one.
  assign half = rcr_q[ssr_pkg::P_WIDE_DIV] ? {divh_q, divl_q} : {8'h00, divl_q};
  // A falling edge of the internal clock phase is the sample point.
  assign fall = (st_q == ssr_pkg::ST_SHIFT) & want & (cnt_q == half) & phase_q;
  // Bits arrive least significant first and enter at the top.
  assign sh_new = {filt_q, sh_q[8:1]};
  assign last = rsc_q[ssr_pkg::P_NINE_EN] ? ssr_pkg::LAST_BIT_9 : ssr_pkg::LAST_BIT_8;
  assign done = fall & (bit_q == last);
  // Low eight bits of the finished word.
  assign word = rsc_q[ssr_pkg::P_NINE_EN] ? sh_new[7:0] : sh_new[8:1];
  // The clock pin idles at the polarity level and is driven while
  // the port is in master sync mode.
  assign shift_clock_o = ((st_q == ssr_pkg::ST_SHIFT) & phase_q)
                         ^ rcr_q[ssr_pkg::P_CLK_POL];
  assign shift_clock_oe_b = ~mode_ok;
  // Read multiplexer; status bits come from live engine state, except the constant framing error and shift idle bits.
  always_comb begin
    rmux = 8'h00;
    unique case (paddr)
      ssr_pkg::OFF_RECEIVE_STATUS_CONTROL: begin
        rmux = rsc_q;
        rmux[ssr_pkg::P_FRAME_ERR] = 1'b0;
        rmux[ssr_pkg::P_OVERRUN] = overrun_error_flag_q;
        rmux[ssr_pkg::P_NINTH_BIT] = ninth_q;
      end
      ssr_pkg::OFF_RECEIVE_DATA_REGISTER: rmux = rxbuf_q;
      ssr_pkg::OFF_TRANSMIT_STATUS_CONTROL: begin
        rmux = txs_q;
        rmux[ssr_pkg::P_SHIFT_IDLE] = 1'b1;
      end
      ssr_pkg::OFF_RATE_CONTROL_REGISTER: begin
        rmux = rcr_q;
        rmux[ssr_pkg::P_RX_IDLE] = (st_q == ssr_pkg::ST_IDLE);
      end
      ssr_pkg::OFF_RATE_DIVISOR_HIGH: rmux = divh_q;
      ssr_pkg::OFF_RATE_DIVISOR_LOW: rmux = divl_q;
      ssr_pkg::OFF_INT_STATUS: rmux = {6'h00, ist_q};
      ssr_pkg::OFF_INT_MASK: rmux = {6'h00, imask_q};
      default: rmux = 8'h00;
    endcase
    prdata_d = prdata_q;
    if (setup) begin
      prdata_d = {24'h000000, rmux};
    end
  end
  // Next values of registers and the receive engine. Hardware clears are
  // applied before software writes, and hardware sets after every clear,
  // so an event in the clearing cycle is never lost.
  always_comb begin
    rsc_d = rsc_q;
    txs_d = txs_q;
    rcr_d = rcr_q;
    divh_d = divh_q;
    divl_d = divl_q;
    rxbuf_d = rxbuf_q;
    full_d = full_q;
    overrun_error_flag_d = overrun_error_flag_q;
    ninth_d = ninth_q;
    ist_d = ist_q;
    imask_d = imask_q;
    st_d = st_q;
    cnt_d = cnt_q;
    phase_d = phase_q;
    bit_d = bit_q;
    sh_d = sh_q;
    // Single mode ends after one word when continuous is off.
    if (done && !rsc_q[ssr_pkg::P_CONT_EN]) begin
      rsc_d[ssr_pkg::P_SINGLE_EN] = 1'b0;
    end
    if (wr) begin
      unique case (paddr)
        ssr_pkg::OFF_RECEIVE_STATUS_CONTROL: begin
          rsc_d = pwdata[7:0] & ssr_pkg::RSC_WR_MASK;
          // Dropping continuous enable clears the latched error.
          if (!pwdata[ssr_pkg::P_CONT_EN]) begin
            overrun_error_flag_d = 1'b0;
          end
        end
        ssr_pkg::OFF_TRANSMIT_STATUS_CONTROL: begin
          txs_d = pwdata[7:0] & ssr_pkg::TXS_WR_MASK;
        end
        ssr_pkg::OFF_RATE_CONTROL_REGISTER: begin
          rcr_d = pwdata[7:0] & ssr_pkg::RCR_WR_MASK;
        end
        ssr_pkg::OFF_RATE_DIVISOR_HIGH: divh_d = pwdata[7:0];
        ssr_pkg::OFF_RATE_DIVISOR_LOW: divl_d = pwdata[7:0];
        ssr_pkg::OFF_INT_STATUS: ist_d = ist_q & ~pwdata[ssr_pkg::INT_W-1:0];
        ssr_pkg::OFF_INT_MASK: imask_d = pwdata[ssr_pkg::INT_W-1:0];
        default: ; // Unmapped writes change nothing and answer with an error.
      endcase
    end
    // Reading the data register empties the buffer.
    if (rd && (paddr == ssr_pkg::OFF_RECEIVE_DATA_REGISTER)) begin
      full_d = 1'b0;
    end
    unique case (st_q)
      ssr_pkg::ST_IDLE: begin
        cnt_d = 16'h0000;
        phase_d = 1'b0;
        bit_d = 4'h0;
        if (want) begin
          st_d = ssr_pkg::ST_SHIFT;
        end
      end
      ssr_pkg::ST_SHIFT: begin
        if (!want) begin
          // Enables cleared or an overrun: stop at once, clock idle.
          st_d = ssr_pkg::ST_IDLE;
          phase_d = 1'b0;
        end else if (cnt_q == half) begin
          // Each half period toggles the shift clock.
          cnt_d = 16'h0000;
          phase_d = ~phase_q;
          if (fall) begin
            sh_d = sh_new;
            bit_d = bit_q + 4'h1;
          end
          if (done) begin
            bit_d = 4'h0;
            if (full_q && !(rd && paddr == ssr_pkg::OFF_RECEIVE_DATA_REGISTER)) begin
              // Unread data still waits: drop the word and halt.
              overrun_error_flag_d = 1'b1;
              ist_d[ssr_pkg::I_OVERRUN] = 1'b1;
            end else begin
              rxbuf_d = word;
              ninth_d = rsc_q[ssr_pkg::P_NINE_EN] & sh_new[8];
              full_d = 1'b1;
              ist_d[ssr_pkg::I_RX_DONE] = 1'b1;
            end
            // Continuous wins over single and keeps going.
            if (!rsc_q[ssr_pkg::P_CONT_EN]) begin
              st_d = ssr_pkg::ST_IDLE;
            end
          end
        end else begin
          cnt_d = cnt_q + 16'h0001;
        end
      end
    endcase
  end

  // Register stage for control, buffer, interrupt and engine state.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rsc_q <= ssr_pkg::REG_RESET;
      txs_q <= ssr_pkg::REG_RESET;
      rcr_q <= ssr_pkg::REG_RESET;
      divh_q <= ssr_pkg::REG_RESET;
      divl_q <= ssr_pkg::REG_RESET;
      rxbuf_q <= ssr_pkg::REG_RESET;
      full_q <= 1'b0;
      overrun_error_flag_q <= 1'b0;
      ninth_q <= 1'b0;
      ist_q <= '0;
      imask_q <= '0;
      st_q <= ssr_pkg::ST_IDLE;
      cnt_q <= 16'h0000;
      phase_q <= 1'b0;
      bit_q <= 4'h0;
      sh_q <= 9'h000;
      prdata_q <= 32'h00000000;
    end else begin
      rsc_q <= rsc_d;
      txs_q <= txs_d;
      rcr_q <= rcr_d;
      divh_q <= divh_d;
      divl_q <= divl_d;
      rxbuf_q <= rxbuf_d;
      full_q <= full_d;
      overrun_error_flag_q <= overrun_error_flag_d;
      ninth_q <= ninth_d;
      ist_q <= ist_d;
      imask_q <= imask_d;
      st_q <= st_d;
      cnt_q <= cnt_d;
      phase_q <= phase_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      prdata_q <= prdata_d;
    end
  end

  // Checks on the engine and register behaviour.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  chk_start_rx: assert property (
    (st_q == ssr_pkg::ST_IDLE) && want |=> (st_q == ssr_pkg::ST_SHIFT))
    else $error("reception did not start");
  chk_sample_fall: assert property (
    fall |=> sh_q == {$past(filt_q), $past(sh_q[8:1])} && !phase_q)
    else $error("bit not sampled at falling edge");
  chk_single_stop: assert property (
    done && !rsc_q[ssr_pkg::P_CONT_EN] && !wr
    |=> (st_q == ssr_pkg::ST_IDLE) && !rsc_q[ssr_pkg::P_SINGLE_EN])
    else $error("single word mode did not stop");
  chk_cont_run: assert property (
    done && rsc_q[ssr_pkg::P_CONT_EN] && !full_q && !wr
    |=> (st_q == ssr_pkg::ST_SHIFT) && (bit_q == 4'h0))
    else $error("continuous mode stopped");
  chk_ninth_bit: assert property (
    done && !full_q |=> ninth_q == ($past(sh_new[8]) & $past(rsc_q[ssr_pkg::P_NINE_EN])))
    else $error("ninth bit not held");
  chk_done_flag: assert property (
    done && !full_q |=> ist_q[ssr_pkg::I_RX_DONE]
    ##0 (irq == imask_q[ssr_pkg::I_RX_DONE] || imask_q[ssr_pkg::I_OVERRUN]))
    else $error("completion flag or interrupt wrong");
  chk_err_report: assert property (
    setup && paddr == ssr_pkg::OFF_RECEIVE_STATUS_CONTROL
    |=> prdata_q[ssr_pkg::P_OVERRUN] == $past(overrun_error_flag_q))
    else $error("overrun not reported");
  chk_data_low: assert property (
    done && !full_q |=> full_q && rxbuf_q == $past(word))
    else $error("received data wrong");
  chk_err_clear: assert property (
    wr && paddr == ssr_pkg::OFF_RECEIVE_STATUS_CONTROL
    && !pwdata[ssr_pkg::P_CONT_EN] && !done |=> !overrun_error_flag_q)
    else $error("error not cleared");
  chk_clk_rate: assert property (
    (st_q == ssr_pkg::ST_SHIFT) && want && (cnt_q != half) && !wr
    |=> $stable(shift_clock_o))
    else $error("shift clock toggled early");
  chk_overrun: assert property (
    done && full_q && !rd |=> overrun_error_flag_q && $stable(rxbuf_q) ##1 (st_q == ssr_pkg::ST_IDLE))
    else $error("overrun not handled");

endmodule
